// ---- verilog/iop_pkg.sv ----
`default_nettype none
package iop_pkg;

    // Port index 0 is port A, 1 is port B, 2 is port C.
    typedef logic [2:0][7:0] iop_vec_t;

    // Register offsets on the byte-wide register port.
    localparam logic [7:0] OFF_DAT_A     = 8'h00;
    localparam logic [7:0] OFF_DIR_A     = 8'h03;
    localparam logic [7:0] OFF_PU_A      = 8'h06;
    localparam logic [7:0] OFF_WAKE_A    = 8'h09;
    localparam logic [7:0] OFF_WAKE_C    = 8'h0A;
    localparam logic [7:0] OFF_BITOP_A   = 8'h0B;
    localparam logic [7:0] OFF_FUNC_SEL  = 8'h0E;
    localparam logic [7:0] OFF_IRQ_STS   = 8'h0F;
    localparam logic [7:0] OFF_IRQ_MSK   = 8'h10;

    // Reset values and implemented-bit masks, ordered {C, B, A}.
    localparam iop_vec_t DAT_RST  = {8'hFF, 8'h3F, 8'hFF};
    localparam iop_vec_t IMPL_MSK = {8'hFF, 8'h3F, 8'hFF};
    localparam iop_vec_t PU_MSK   = {8'hFF, 8'h3F, 8'h7F};
    localparam iop_vec_t WK_MSK   = {8'hFF, 8'h00, 8'hFF};

    // Shared-pin positions.
    localparam int INT_BIT  = 3;
    localparam int TC0_BIT  = 6;
    localparam int TC1_BIT  = 2;
    localparam int PFD0_BIT = 4;
    localparam int PFD1_BIT = 5;
    localparam logic [7:0] LCD_PINS  = 8'h0F;
    localparam logic [7:0] CMP_PINS  = 8'h03;
    localparam logic [7:0] AMP0_PA   = 8'h1C;
    localparam logic [7:0] AMP1_PA   = 8'h03;
    localparam logic [7:0] AMP1_PC   = 8'h40;

    // Pin-function select register fields.
    localparam int FS_PFD0 = 0;
    localparam int FS_PFD1 = 1;
    localparam int FS_LCD  = 2;
    localparam int FS_CMP  = 3;
    localparam int FS_AMP0 = 4;
    localparam int FS_AMP1 = 5;
    localparam logic [7:0] FS_MSK = 8'h3F;

    // Interrupt status and mask fields.
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_INT  = 1;

    typedef struct packed {
        logic       int_en;
        logic [1:0] tmr_ext;
        logic [1:0] frequency_divider_output;
    } iop_share_t;

    typedef struct packed {
        logic [1:0] tmr_pin;
        logic [3:0] lcd_sel;
        logic       int_pin;
    } iop_side_t;

    typedef struct packed {
        iop_vec_t   dat;
        iop_vec_t   dir;
        iop_vec_t   pu;
        iop_vec_t   wk;
        logic [7:0] fsel;
        logic [1:0] sts;
        logic [1:0] msk;
        logic [7:0] rdata;
        iop_vec_t   syn1;
        iop_vec_t   syn2;
        iop_vec_t   prv;
        iop_vec_t   pad_out;
        iop_vec_t   pad_oe;
        iop_vec_t   pad_pu;
        logic       irq;
        iop_side_t  side;
    } iop_st_t;

endpackage : iop_pkg
`default_nettype wire

// ---- verilog/iop_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Direction bit 1 makes a pin input, 0 a push-pull output from the latch.
// - Reading an input pin's data returns the level on the pin.
// - Reading an output pin's data returns the latch, not the pin.
// - Reset sets all latches and direction bits high; port B to 3F.
// - A pin turned to output drives its latch, high if never written.
// - Bit set or clear reads the whole port, alters one bit, writes back.
// - Enabled port A or C pin falling in Idle or Sleep wakes the device.
// - Only ports A and C can wake; any pin combination may be enabled.
// - Pull-up enable 1 connects a weak pull-up while the pin is an input.
// - Unimplemented pull-up and direction bits read as zero.
// - Timer pin counts only in event or capture mode and as an input.
// - Divider outputs drive only when selected and the pin is an output.
// - Port B pins 0 to 3 can be switched to LCD common drivers.
// - Comparator inputs on port C force their pull-ups off.
// - Amplifier pins lose port I/O and pull-up automatically; the wake output and the INT pin still see them.
// - Inputs are not latched; a read samples the pin at the read.
// - Port A bit 7 has no pull-up control bit.
module iop_top
    import iop_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            irq,
    output logic            wake,
    input  wire iop_vec_t   pad_in,
    output iop_vec_t        pad_out,
    output iop_vec_t        pad_oe,
    output iop_vec_t        pad_pu,
    input  wire iop_share_t share,
    output iop_side_t       side
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    iop_st_t s;
    iop_st_t n;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // One pass computes register updates, pin drive and events.
    // Pin drive is taken from the next state so that every pad
    // output is a flop yet follows its register without lag.
    always_comb
    begin
        iop_vec_t   view;
        iop_vec_t   amp;
        iop_vec_t   fall;
        logic [7:0] tmp;
        logic       wev;
        logic       iev;
        view = '0;
        amp  = '0;
        fall = '0;
        tmp  = '0;
        wev  = 1'b0;
        iev  = 1'b0;
        n    = s;

        // Amplifier pins are removed from port reads and wake status.
        amp[0] = (s.fsel[FS_AMP0] ? AMP0_PA : 8'h00)
               | (s.fsel[FS_AMP1] ? AMP1_PA : 8'h00);
        amp[2] = s.fsel[FS_AMP1] ? AMP1_PC : 8'h00;

        // Port view: synchronised pin for inputs, latch for outputs.
        // The pin is sampled live; nothing holds it between reads.
        for (int p = 0; p < 3; p++)
        begin
            view[p] = ((s.syn2[p] & s.dir[p])
                    | (s.dat[p] & ~s.dir[p]))
                    & IMPL_MSK[p] & ~amp[p];
        end

        // Input synchronisers; the first stage feeds only the second.
        n.syn1 = pad_in;
        n.syn2 = s.syn1;
        n.prv  = s.syn2;
        for (int p = 0; p < 3; p++)
        begin
            fall[p] = s.prv[p] & ~s.syn2[p];
        end

        // Read data stands for exactly one cycle after the strobe.
        n.rdata = 8'h00;
        if (rd)
        begin
            for (int p = 0; p < 3; p++)
            begin
                if (addr == OFF_DAT_A + 8'(p))
                begin
                    n.rdata = view[p];
                end
                if (addr == OFF_DIR_A + 8'(p))
                begin
                    n.rdata = s.dir[p];
                end
                if (addr == OFF_PU_A + 8'(p))
                begin
                    n.rdata = s.pu[p];
                end
            end
            case (addr)
                OFF_WAKE_A:   n.rdata = s.wk[0];
                OFF_WAKE_C:   n.rdata = s.wk[2];
                OFF_FUNC_SEL: n.rdata = s.fsel;
                OFF_IRQ_STS:  n.rdata = {6'h00, s.sts};
                OFF_IRQ_MSK:  n.rdata = {6'h00, s.msk};
                default:      ;
            endcase
        end

        // Register writes; unimplemented bits never store.
        if (wr)
        begin
            for (int p = 0; p < 3; p++)
            begin
                if (addr == OFF_DAT_A + 8'(p))
                begin
                    n.dat[p] = wdata & IMPL_MSK[p];
                end
                if (addr == OFF_DIR_A + 8'(p))
                begin
                    n.dir[p] = wdata & IMPL_MSK[p];
                end
                if (addr == OFF_PU_A + 8'(p))
                begin
                    n.pu[p] = wdata & PU_MSK[p];
                end
                // Bit op: wdata[2:0] picks the bit, wdata[3] the value.
                // Input bits copy the pin level into their latch, as
                // a whole-port write-back does.
                if (addr == OFF_BITOP_A + 8'(p))
                begin
                    tmp = view[p];
                    tmp[wdata[2:0]] = wdata[3];
                    n.dat[p] = tmp & IMPL_MSK[p];
                end
            end
            case (addr)
                OFF_WAKE_A:   n.wk[0] = wdata & WK_MSK[0];
                OFF_WAKE_C:   n.wk[2] = wdata & WK_MSK[2];
                OFF_FUNC_SEL: n.fsel = wdata & FS_MSK;
                OFF_IRQ_STS:  n.sts = s.sts & ~wdata[1:0];
                OFF_IRQ_MSK:  n.msk = wdata[1:0];
                default:      ;
            endcase
        end

        // Events; a set in the clearing cycle wins over the clear.
        wev = |((fall[0] & s.wk[0] & ~amp[0])
              | (fall[2] & s.wk[2] & ~amp[2]));
        iev = share.int_en & s.dir[0][INT_BIT]
            & fall[0][INT_BIT];
        if (wev)
        begin
            n.sts[IRQ_WAKE] = 1'b1;
        end
        if (iev)
        begin
            n.sts[IRQ_INT] = 1'b1;
        end

        // Reset values; reset overrides the clock enable.
        if (!rst_n)
        begin
            n      = '0;
            n.dat  = DAT_RST;
            n.dir  = DAT_RST;
            n.syn1 = pad_in;
            n.syn2 = s.syn1;
            n.prv  = s.syn2;
        end

        // Pad drive follows the next register state.
        for (int p = 0; p < 3; p++)
        begin
            n.pad_out[p] = n.dat[p];
            n.pad_oe[p]  = ~n.dir[p] & IMPL_MSK[p];
            n.pad_pu[p]  = n.pu[p] & n.dir[p];
        end
        amp[0] = (n.fsel[FS_AMP0] ? AMP0_PA : 8'h00)
               | (n.fsel[FS_AMP1] ? AMP1_PA : 8'h00);
        amp[2] = n.fsel[FS_AMP1] ? AMP1_PC : 8'h00;
        for (int p = 0; p < 3; p++)
        begin
            n.pad_oe[p] = n.pad_oe[p] & ~amp[p];
            n.pad_pu[p] = n.pad_pu[p] & ~amp[p];
        end

        // Divider outputs replace the latch on output pins only.
        if (n.fsel[FS_PFD0] && !n.dir[1][PFD0_BIT])
        begin
            n.pad_out[1][PFD0_BIT] = share.frequency_divider_output[0];
        end
        if (n.fsel[FS_PFD1] && !n.dir[1][PFD1_BIT])
        begin
            n.pad_out[1][PFD1_BIT] = share.frequency_divider_output[1];
        end

        // LCD commons are driven by the bias network, not the port.
        if (n.fsel[FS_LCD])
        begin
            n.pad_oe[1] = n.pad_oe[1] & ~LCD_PINS;
            n.pad_pu[1] = n.pad_pu[1] & ~LCD_PINS;
        end

        // Comparator inputs must not be loaded by a pull-up.
        if (n.fsel[FS_CMP])
        begin
            n.pad_pu[2] = n.pad_pu[2] & ~CMP_PINS;
        end

        // Shared inputs for the timers and the interrupt logic.
        n.side.tmr_pin[0] = share.tmr_ext[0]
                          & s.dir[0][TC0_BIT]
                          & s.syn2[0][TC0_BIT];
        n.side.tmr_pin[1] = share.tmr_ext[1]
                          & s.dir[2][TC1_BIT]
                          & s.syn2[2][TC1_BIT];
        n.side.int_pin = s.dir[0][INT_BIT]
                       & s.syn2[0][INT_BIT];
        n.side.lcd_sel = n.fsel[FS_LCD] ? LCD_PINS[3:0] : 4'h0;
        n.irq = |(n.sts & n.msk);
        if (!rst_n)
        begin
            n.irq  = 1'b0;
            n.side = '0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // All state freezes while the clock enable is low and reset is high.
    always_ff @(posedge mclk)
    begin
        if (ce || !rst_n)
        begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign rdata   = s.rdata;
    assign irq     = s.irq;
    assign pad_out = s.pad_out;
    assign pad_oe  = s.pad_oe;
    assign pad_pu  = s.pad_pu;
    assign side    = s.side;

    // Wake is purely combinational from the raw pads, since the
    // clock is stopped while it matters; it is a level that rises
    // when an enabled pin is pulled low.
    assign wake = |((~pad_in[0] & s.wk[0])
                  | (~pad_in[2] & s.wk[2]));

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    localparam logic [7:0] OFF_DIR_C_CHK = OFF_DIR_A + 8'h02;

    sequence dir_c_write;
        ce && wr && addr == OFF_DIR_C_CHK && !s.fsel[FS_AMP1];
    endsequence

    dir_out_a: assert property (dir_c_write |=>
        pad_oe[2] == ~$past(wdata))
        else $error("port C enable does not follow direction");

    read_view_a: assert property (
        (ce && rd && addr == OFF_DAT_A && s.fsel == 8'h00) |=>
        rdata == (($past(s.syn2[0]) & $past(s.dir[0]))
              | ($past(s.dat[0]) & ~$past(s.dir[0]))))
        else $error("port A read returned wrong source");

    reset_val_a: assert property (
        (ce && !$past(rst_n)) |->
        s.dir == DAT_RST && s.dat == DAT_RST)
        else $error("reset values wrong");

    latch_drv_a: assert property (
        ((pad_oe[2] & (pad_out[2] ^ s.dat[2])) == 8'h00))
        else $error("output pin does not drive its latch");

    sequence bitop_a_write;
        ce && wr && addr == OFF_BITOP_A && s.fsel == 8'h00;
    endsequence

    bitop_rmw_a: assert property (bitop_a_write |=>
        s.dat[0][$past(wdata[2:0])] == $past(wdata[3]))
        else $error("bit op did not alter the chosen bit");

    wake_sts_a: assert property (
        (ce && |(s.prv[0] & ~s.syn2[0] & s.wk[0])
         && s.fsel == 8'h00) |=> s.sts[IRQ_WAKE])
        else $error("enabled falling edge did not set wake");

    pu_a7_a: assert property (
        !s.pu[0][7] && !pad_pu[0][7] && s.dir[1][7:6] == 2'b00)
        else $error("unimplemented bit stored");

    pull_in_a: assert property (
        (pad_pu[2] & ~s.dir[2]) == 8'h00)
        else $error("pull-up on an output pin");

    cmp_pu_a: assert property (
        s.fsel[FS_CMP] |-> (pad_pu[2] & CMP_PINS) == 8'h00)
        else $error("comparator pin kept pull-up");

    amp_off_a: assert property (
        s.fsel[FS_AMP0] |->
        ((pad_oe[0] | pad_pu[0]) & AMP0_PA) == 8'h00)
        else $error("amplifier pin still digital");

    lcd_off_a: assert property (
        s.fsel[FS_LCD] |-> (pad_oe[1] & LCD_PINS) == 8'h00)
        else $error("LCD common pin still driven");

    pfd_drv_a: assert property (
        (ce && n.fsel[FS_PFD0] && !n.dir[1][PFD0_BIT]) |=>
        pad_out[1][PFD0_BIT] == $past(share.frequency_divider_output[0]))
        else $error("divider output not on pin");

    tmr_gate_a: assert property (
        (ce && !share.tmr_ext[0]) |=> !side.tmr_pin[0])
        else $error("timer pin active outside event mode");

endmodule : iop_top
`default_nettype wire

// ---- test/iop_pins.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Board side: switches on the pins and the weak pull-ups
// ----------------------------------------------------------------
// A pin that nobody drives or pulls flips every cycle, so a read of a
// floating pin cannot pass by luck.
module iop_pins
    import iop_pkg::*;
(
    input  wire logic     mclk,
    input  wire iop_vec_t pad_out,
    input  wire iop_vec_t pad_oe,
    input  wire iop_vec_t pad_pu,
    input  wire iop_vec_t ext_en,
    input  wire iop_vec_t ext_val,
    output iop_vec_t      pad_in
);
    logic flt_q = 1'b0;

    // Floating level changes each cycle.
    always @(posedge mclk)
        flt_q <= ~flt_q;

    // Device drive wins, then the switch, then the pull-up.
    assign pad_in = (pad_oe & pad_out)
                  | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & pad_pu)
                  | (~pad_oe & ~ext_en & ~pad_pu & {24{flt_q}});
endmodule : iop_pins
`default_nettype wire

// ---- test/io_port_with_wakeup_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module io_port_with_wakeup_test;
    import iop_pkg::*;

    logic       mclk      = 1'b0;
    logic       rst_n     = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic       ce        = 1'b1;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    iop_vec_t   pad_in;
    iop_vec_t   pad_out;
    iop_vec_t   pad_oe;
    iop_vec_t   pad_pu;
    iop_share_t share     = '0;
    iop_side_t  side;
    iop_vec_t   ext_en    = {3{8'hFF}};
    iop_vec_t   ext_val   = {8'h96, 8'h25, 8'hA5};
    int         failures  = 0;
    int         tests_run = 0;
    int         cyc       = 0;

    iop_top u_iop_top (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .wake(wake), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pu(pad_pu), .share(share), .side(side));

    iop_pins u_iop_pins (.mclk(mclk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pu(pad_pu), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));

    // 100 MHz clock.
    always #5 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // A hung handshake would stall forever, so cap the run length.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            failures++;
            give_verdict();
        end
    end

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp8

    task automatic cmp1(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: flag %b want %b", $time, g, e);
        end
    endtask : cmp1

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 cmp8(rdata, e);
    endtask : rd_chk

    // Pads are registered behind two synchroniser flops.
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_n

    task automatic pins(input iop_vec_t v);
        @(posedge mclk);
        ext_val <= v;
    endtask : pins

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] rv [8] = '{8'hFF, 8'h3F, 8'hFF, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
            rd_chk(OFF_DIR_A + 8'(i), rv[i]);
        for (int p = 0; p < 3; p++)
        begin
            cmp8(pad_oe[p], 8'h00);
            cmp8(pad_out[p], DAT_RST[p]);
        end
        rd_chk(OFF_DAT_A, 8'hA5);
        rd_chk(OFF_DAT_A + 8'h01, 8'h25);
        rd_chk(OFF_DAT_A + 8'h02, 8'h96);
        rd_chk(8'hFF, 8'h00);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_io();
        wr_reg(OFF_DIR_A, 8'hF0);
        wait_n(3);
        cmp8(pad_oe[0], 8'h0F);
        cmp8(pad_out[0] & 8'h0F, 8'h0F);
        rd_chk(OFF_DAT_A, 8'hAF);
        wr_reg(OFF_DAT_A, 8'h00);
        pins({8'h96, 8'h25, 8'h5A});
        wait_n(3);
        cmp8(pad_out[0] & 8'h0F, 8'h00);
        rd_chk(OFF_DAT_A, 8'h50);
        $display("t_io done");
    endtask : t_io

    task automatic t_unimpl();
        wr_reg(OFF_PU_A, 8'hFF);
        rd_chk(OFF_PU_A, 8'h7F);
        wait_n(3);
        cmp8(pad_pu[0], 8'h70);
        wr_reg(OFF_DIR_A + 8'h01, 8'hFF);
        rd_chk(OFF_DIR_A + 8'h01, 8'h3F);
        wr_reg(OFF_PU_A + 8'h01, 8'hFF);
        rd_chk(OFF_PU_A + 8'h01, 8'h3F);
        // With the clock enable low a write must leave no trace.
        @(posedge mclk);
        ce <= 1'b0;
        wr_reg(OFF_PU_A + 8'h01, 8'h00);
        @(posedge mclk);
        ce <= 1'b1;
        rd_chk(OFF_PU_A + 8'h01, 8'h3F);
        $display("t_unimpl done");
    endtask : t_unimpl

    // Input bits of the port are copied into the latch by a bit op.
    task automatic t_bitop();
        wr_reg(OFF_BITOP_A, 8'h09);
        rd_chk(OFF_DAT_A, 8'h52);
        wr_reg(OFF_DIR_A, 8'h00);
        wait_n(3);
        cmp8(pad_out[0], 8'h52);
        wr_reg(OFF_BITOP_A, 8'h01);
        rd_chk(OFF_DAT_A, 8'h50);
        wr_reg(OFF_DIR_A, 8'hFF);
        $display("t_bitop done");
    endtask : t_bitop

    task automatic t_wake();
        wr_reg(OFF_WAKE_A, 8'h81);
        wr_reg(OFF_WAKE_C, 8'h80);
        pins({3{8'hFF}});
        wait_n(4);
        wr_reg(OFF_IRQ_STS, 8'h03);
        wait_n(2);
        cmp1(wake, 1'b0);
        pins({8'hFF, 8'h00, 8'hFF});
        wait_n(4);
        cmp1(wake, 1'b0);
        pins({8'h7F, 8'h00, 8'hFF});
        #1 cmp1(wake, 1'b1);
        wait_n(4);
        cmp1(irq, 1'b0);
        rd_chk(OFF_IRQ_STS, 8'h01);
        wr_reg(OFF_IRQ_MSK, 8'h01);
        wait_n(2);
        cmp1(irq, 1'b1);
        wr_reg(OFF_IRQ_STS, 8'h01);
        wait_n(2);
        cmp1(irq, 1'b0);
        pins({8'hFF, 8'h3F, 8'h7F});
        #1 cmp1(wake, 1'b1);
        pins({3{8'hFF}});
        // Let the short port A pulse reach the status bit first.
        wait_n(4);
        cmp1(irq, 1'b1);
        wr_reg(OFF_IRQ_STS, 8'h01);
        wait_n(2);
        cmp1(irq, 1'b0);
        cmp1(wake, 1'b0);
        rd_chk(OFF_IRQ_STS, 8'h00);
        $display("t_wake done");
    endtask : t_wake

    task automatic t_int();
        @(posedge mclk);
        share.int_en <= 1'b1;
        pins({8'hFF, 8'hFF, 8'hF7});
        wait_n(4);
        rd_chk(OFF_IRQ_STS, 8'h02);
        cmp1(side.int_pin, 1'b0);
        rd_chk(OFF_DAT_A, 8'hF7);
        pins({3{8'hFF}});
        wait_n(4);
        cmp1(side.int_pin, 1'b1);
        wr_reg(OFF_IRQ_STS, 8'h02);
        $display("t_int done");
    endtask : t_int

    task automatic t_share();
        @(posedge mclk);
        share.tmr_ext <= 2'b01;
        wait_n(3);
        cmp1(side.tmr_pin[0], 1'b1);
        wr_reg(OFF_DIR_A, 8'hBF);
        wait_n(3);
        cmp1(side.tmr_pin[0], 1'b0);
        wr_reg(OFF_DIR_A, 8'hFF);
        wr_reg(OFF_FUNC_SEL, 8'h01);
        wr_reg(OFF_DIR_A + 8'h01, 8'h2F);
        share.frequency_divider_output <= 2'b01;
        wait_n(3);
        cmp1(pad_out[1][4], 1'b1);
        cmp1(pad_oe[1][4], 1'b1);
        @(posedge mclk);
        share.frequency_divider_output <= 2'b00;
        wait_n(3);
        cmp1(pad_out[1][4], 1'b0);
        wr_reg(OFF_DIR_A + 8'h01, 8'h30);
        wr_reg(OFF_FUNC_SEL, 8'h04);
        wait_n(3);
        cmp8({4'h0, side.lcd_sel}, 8'h0F);
        cmp8(pad_oe[1] & 8'h0F, 8'h00);
        wr_reg(OFF_PU_A + 8'h02, 8'hFF);
        wr_reg(OFF_FUNC_SEL, 8'h08);
        wait_n(3);
        cmp8(pad_pu[2], 8'hFC);
        wr_reg(OFF_FUNC_SEL, 8'h10);
        wait_n(3);
        cmp8(pad_pu[0], 8'h63);
        cmp8(pad_pu[2], 8'hFF);
        rd_chk(OFF_DAT_A, 8'hE3);
        // Second amplifier and second divider; the divider is low
        // while the latch is high, so the pin shows who drives it.
        wr_reg(OFF_FUNC_SEL, 8'h22);
        wr_reg(OFF_DIR_A + 8'h01, 8'h1F);
        wait_n(3);
        cmp1(pad_out[1][5], 1'b0);
        cmp1(pad_oe[1][5], 1'b1);
        cmp8(pad_pu[0] & 8'h03, 8'h00);
        cmp1(pad_pu[2][6], 1'b0);
        rd_chk(OFF_DAT_A + 8'h02, 8'hBF);
        wr_reg(OFF_DIR_A + 8'h01, 8'h3F);
        wait_n(3);
        cmp1(pad_oe[1][5], 1'b0);
        cmp1(pad_pu[1][5], 1'b1);
        wr_reg(OFF_FUNC_SEL, 8'h00);
        wr_reg(OFF_DIR_A + 8'h02, 8'h7F);
        wait_n(3);
        cmp1(pad_oe[2][7], 1'b1);
        cmp1(pad_out[2][7], 1'b1);
        $display("t_share done");
    endtask : t_share

    // Main sequence: reset held for 16 cycles, then the scenarios.
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        wait_n(3);
        t_reset();
        t_io();
        t_unimpl();
        t_bitop();
        t_wake();
        t_int();
        t_share();
        give_verdict();
    end
endmodule : io_port_with_wakeup_test
`default_nettype wire
